// ==== chop_detect_regs.svh ====
`ifndef CHOP_DETECT_REGS_SVH
`define CHOP_DETECT_REGS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CHOP_DETECT_CONFIG   6'h06
`define IDX_THRESHOLD_UPPER      6'h07
`define IDX_THRESHOLD_LOWER      6'h08
`define IDX_EVENT_STATUS         6'h10
`define IDX_EVENT_MASK           6'h11
`define IDX_LIVE_STATUS          6'h12
`define AXI_ADDR_WIDTH           8

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define CFG_CHOP_DELAY_LSB       9
`define CFG_CHOP_DELAY_MSB       12
`define CFG_CHOP_ENABLE_BIT      8
`define CFG_ALL_CHANNELS_BIT     7
`define CFG_EXCEED_LSB           4
`define CFG_EXCEED_MSB           6
`define CFG_WINDOW_LSB           1
`define CFG_WINDOW_MSB           3
`define CFG_DETECT_ENABLE_BIT    0
`define CFG_WRITE_MASK           16'h1fff
`define LOWER_THRESHOLD_MASK     16'hff00
`define EVT_DETECT_BIT           0
`define EVT_SETTLED_BIT          1
`define EVT_MASK                 16'h0003
`define CHANNELS                 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CHOP_DETECT_CONFIG   16'h0600
`define RST_THRESHOLD_UPPER      16'h0000
`define RST_THRESHOLD_LOWER      16'h0000

// ----------------------------------------
// Window lengths in conversion periods
// ----------------------------------------
`define WIN_LEN_0                12'h080
`define WIN_LEN_1                12'h100
`define WIN_LEN_2                12'h200
`define WIN_LEN_3                12'h300
`define WIN_LEN_4                12'h500
`define WIN_LEN_5                12'h700
`define WIN_LEN_6                12'ha00
`define WIN_LEN_7                12'he00

`define AXI_RESP_OKAY            2'b00
`define AXI_RESP_SLVERR          2'b10

`endif

// ==== chop_detect_pkg.sv ====
`default_nettype none
`include "chop_detect_regs.svh"

package chop_detect_pkg;

	typedef logic [15:0] reg16_t;
	typedef logic [23:0] sample_t;
	typedef logic [5:0]  reg_index_t;

	// Settling delay of 2^(code+1) modulator periods
	function automatic logic [16:0] chop_periods(input logic [3:0] code);
		chop_periods = 17'h0_0001 << ({1'b0, code} + 5'h01);
	endfunction : chop_periods

	// Exceedances needed: 2^code
	function automatic logic [7:0] exceed_needed(input logic [2:0] code);
		exceed_needed = 8'h01 << code;
	endfunction : exceed_needed

	function automatic logic [11:0] window_periods(input logic [2:0] code);
		case (code)
			3'h0:    window_periods = `WIN_LEN_0;
			3'h1:    window_periods = `WIN_LEN_1;
			3'h2:    window_periods = `WIN_LEN_2;
			3'h3:    window_periods = `WIN_LEN_3;
			3'h4:    window_periods = `WIN_LEN_4;
			3'h5:    window_periods = `WIN_LEN_5;
			3'h6:    window_periods = `WIN_LEN_6;
			default: window_periods = `WIN_LEN_7;
		endcase
	endfunction : window_periods

	// Byte-lane merge of a 16-bit register
	function automatic reg16_t apply_strobe(input reg16_t old, input reg16_t wr,
						input logic [1:0] strb);
		apply_strobe = {strb[1] ? wr[15:8] : old[15:8], strb[0] ? wr[7:0] : old[7:0]};
	endfunction : apply_strobe

endpackage : chop_detect_pkg

`default_nettype wire

// ==== chop_settle_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

module chop_settle_timer (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       chop_enable,
	input  wire logic [3:0] chop_settle_delay,
	input  wire logic       chop_phase_start,
	input  wire logic       mod_tick,
	output logic            settled,
	output logic            settle_done
);
	import chop_detect_pkg::*;

	logic [16:0] remaining;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			remaining   <= 17'h0_0000;
			settled     <= 1'b1;
			settle_done <= 1'b0;
		end else if (!chop_enable) begin
			// Setting kept in the register, no delay applied
			remaining   <= 17'h0_0000;
			settled     <= 1'b1;
			settle_done <= 1'b0;
		end else if (chop_phase_start) begin
			remaining   <= chop_periods(chop_settle_delay);
			settled     <= 1'b0;
			settle_done <= 1'b0;
		end else if (mod_tick && remaining != 17'h0_0000) begin
			remaining   <= remaining - 17'h0_0001;
			settled     <= (remaining == 17'h0_0001);
			settle_done <= (remaining == 17'h0_0001);
		end else begin
			settle_done <= 1'b0;
		end
	end

endmodule : chop_settle_timer

`default_nettype wire

// ==== exceed_counter.sv ====
`timescale 1ns/100ps
`default_nettype none

module exceed_counter (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        clear,
	input  wire logic        sample_valid,
	input  wire logic [23:0] sample,
	input  wire logic [23:0] threshold,
	input  wire logic [7:0]  needed,
	output logic             reached
);
	import chop_detect_pkg::*;

	logic [7:0]  count;
	logic [7:0]  base;
	logic [7:0]  next_count;
	sample_t     magnitude;
	logic        exceeds;

	// Two's complement magnitude; full-scale negative maps to 2^23 unsigned
	assign magnitude  = sample[23] ? (~sample + 24'h00_0001) : sample;
	assign exceeds    = sample_valid && (magnitude > threshold);
	assign base       = clear ? 8'h00 : count;
	// Saturate so 128 needed exceedances stays reachable
	assign next_count = (exceeds && base != 8'hff) ? base + 8'h01 : base;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count   <= 8'h00;
			reached <= 1'b0;
		end else begin
			count   <= next_count;
			reached <= (next_count >= needed);
		end
	end

endmodule : exceed_counter

`default_nettype wire

// ==== chop_and_current_detect_config.sv ====
// Notes on behaviour
// - With chopping on, measurement waits 2^(setting+1) modulator periods, 2 up to 65536.
// - The chop delay field resets to code 3, meaning 16 modulator periods.
// - The channel select bit picks any-channel triggering when 0 and all-channel when 1.
// - Detection needs 2^code threshold exceedances, 1 at reset up to 128.
// - The measurement window lasts 128 to 3584 conversion periods by code, 128 at reset.
// - Current detection runs only while bit 0 of the config is set, and that bit resets to 0.
// - A 16-bit read/write register holds the upper threshold bits and resets to zero.
// - The lower 8 threshold bits sit in bits 15:8 of the next register, read/write, reset 0.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "chop_detect_regs.svh"

module chop_and_current_detect_config (
	input  wire logic                          clock,
	input  wire logic                          nrst,
	// AXI4-Lite write address
	input  wire logic [`AXI_ADDR_WIDTH-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [`AXI_ADDR_WIDTH-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Converter side
	input  wire logic                          mod_tick,
	input  wire logic                          chop_phase_start,
	input  wire logic                          conv_valid,
	input  wire logic [`CHANNELS-1:0][23:0]    ch_sample,
	output logic                               measure_enable,
	output logic                               detect_event,
	output logic                               irq
);
	import chop_detect_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg16_t      chop_detect_config;
	reg16_t      detect_threshold_upper;
	reg16_t      threshold_lower_reg;
	reg16_t      event_status;
	reg16_t      event_mask;

	logic [3:0]  chop_settle_delay;
	logic        chop_enable;
	logic        detect_all_channels;
	logic [2:0]  detect_exceed_count;
	logic [2:0]  detect_window_length;
	logic        detect_mode_enable;
	logic [7:0]  detect_threshold_low;
	sample_t     threshold;

	assign chop_settle_delay    = chop_detect_config[`CFG_CHOP_DELAY_MSB:`CFG_CHOP_DELAY_LSB];
	assign chop_enable          = chop_detect_config[`CFG_CHOP_ENABLE_BIT];
	assign detect_all_channels  = chop_detect_config[`CFG_ALL_CHANNELS_BIT];
	assign detect_exceed_count  = chop_detect_config[`CFG_EXCEED_MSB:`CFG_EXCEED_LSB];
	assign detect_window_length = chop_detect_config[`CFG_WINDOW_MSB:`CFG_WINDOW_LSB];
	assign detect_mode_enable   = chop_detect_config[`CFG_DETECT_ENABLE_BIT];
	assign detect_threshold_low = threshold_lower_reg[15:8];
	assign threshold            = {detect_threshold_upper, detect_threshold_low};

	// ----------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------
	logic                       aw_take;
	logic                       w_take;
	logic                       ar_take;
	logic                       aw_held;
	logic                       w_held;
	logic                       do_write;
	logic                       next_aw_held;
	logic                       next_w_held;
	reg_index_t                 wr_index;
	reg16_t                     wr_data;
	logic [1:0]                 wr_strb;
	reg_index_t                 rd_index;

	assign aw_take      = s_axi_awvalid && s_axi_awready;
	assign w_take       = s_axi_wvalid && s_axi_wready;
	assign ar_take      = s_axi_arvalid && s_axi_arready;
	assign do_write     = aw_held && w_held && !s_axi_bvalid;
	assign next_aw_held = do_write ? 1'b0 : (aw_held || aw_take);
	assign next_w_held  = do_write ? 1'b0 : (w_held || w_take);
	assign rd_index     = s_axi_araddr[`AXI_ADDR_WIDTH-1:2];

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b0;
			wr_index      <= 6'h00;
		end else begin
			aw_held       <= next_aw_held;
			s_axi_awready <= !next_aw_held;
			if (aw_take) begin
				wr_index <= s_axi_awaddr[`AXI_ADDR_WIDTH-1:2];
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b0;
			wr_data      <= 16'h0000;
			wr_strb      <= 2'b00;
		end else begin
			w_held       <= next_w_held;
			s_axi_wready <= !next_w_held;
			if (w_take) begin
				wr_data <= s_axi_wdata[15:0];
				wr_strb <= s_axi_wstrb[1:0];
			end
		end
	end

	function automatic logic index_mapped(input reg_index_t idx);
		index_mapped = (idx == `IDX_CHOP_DETECT_CONFIG) || (idx == `IDX_THRESHOLD_UPPER) ||
			       (idx == `IDX_THRESHOLD_LOWER) || (idx == `IDX_EVENT_STATUS) ||
			       (idx == `IDX_EVENT_MASK) || (idx == `IDX_LIVE_STATUS);
	endfunction : index_mapped

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= index_mapped(wr_index) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic wr_config;
	logic wr_upper;
	logic wr_lower;
	logic wr_status;
	logic wr_mask;

	assign wr_config = do_write && wr_index == `IDX_CHOP_DETECT_CONFIG;
	assign wr_upper  = do_write && wr_index == `IDX_THRESHOLD_UPPER;
	assign wr_lower  = do_write && wr_index == `IDX_THRESHOLD_LOWER;
	assign wr_status = do_write && wr_index == `IDX_EVENT_STATUS;
	assign wr_mask   = do_write && wr_index == `IDX_EVENT_MASK;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			chop_detect_config <= `RST_CHOP_DETECT_CONFIG;
		end else if (wr_config) begin
			// Top reserved bits forced low in case software slips
			chop_detect_config <= apply_strobe(chop_detect_config, wr_data, wr_strb)
					      & `CFG_WRITE_MASK;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			detect_threshold_upper <= `RST_THRESHOLD_UPPER;
		end else if (wr_upper) begin
			detect_threshold_upper <= apply_strobe(detect_threshold_upper, wr_data, wr_strb);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			threshold_lower_reg <= `RST_THRESHOLD_LOWER;
		end else if (wr_lower) begin
			threshold_lower_reg <= apply_strobe(threshold_lower_reg, wr_data, wr_strb)
					       & `LOWER_THRESHOLD_MASK;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			event_mask <= 16'h0000;
		end else if (wr_mask) begin
			event_mask <= apply_strobe(event_mask, wr_data, wr_strb) & `EVT_MASK;
		end
	end

	// ----------------------------------------
	// Chop settling
	// ----------------------------------------
	logic settle_done;

	chop_settle_timer settle_timer (
		.clock             (clock),
		.nrst              (nrst),
		.chop_enable       (chop_enable),
		.chop_settle_delay (chop_settle_delay),
		.chop_phase_start  (chop_phase_start),
		.mod_tick          (mod_tick),
		.settled           (measure_enable),
		.settle_done       (settle_done)
	);

	// ----------------------------------------
	// Current detection window
	// ----------------------------------------
	logic                   window_active;
	logic [11:0]            window_count;
	logic                   window_restart;
	logic                   fired;
	logic                   counters_clear;
	logic                   sample_in;
	logic [`CHANNELS-1:0]   reached;
	logic                   condition_met;

	// Samples arriving during chop settling are not counted
	assign window_active  = detect_mode_enable && measure_enable;
	assign sample_in      = window_active && conv_valid;
	assign counters_clear = window_restart || !window_active;
	assign condition_met  = detect_all_channels ? &reached : |reached;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			window_count   <= 12'h000;
			window_restart <= 1'b0;
		end else if (!window_active) begin
			window_count   <= 12'h000;
			window_restart <= 1'b0;
		end else if (conv_valid) begin
			// Last conversion of the window rolls the count over
			if (window_count + 12'h001 >= window_periods(detect_window_length)) begin
				window_count   <= 12'h000;
				window_restart <= 1'b1;
			end else begin
				window_count   <= window_count + 12'h001;
				window_restart <= 1'b0;
			end
		end else begin
			window_restart <= 1'b0;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < `CHANNELS; ch++) begin : g_channel
			exceed_counter counter (
				.clock        (clock),
				.nrst         (nrst),
				.clear        (counters_clear),
				.sample_valid (sample_in),
				.sample       (ch_sample[ch]),
				.threshold    (threshold),
				.needed       (exceed_needed(detect_exceed_count)),
				.reached      (reached[ch])
			);
		end
	endgenerate

	// One detection per window at most
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fired        <= 1'b0;
			detect_event <= 1'b0;
		end else if (counters_clear) begin
			fired        <= 1'b0;
			detect_event <= 1'b0;
		end else begin
			fired        <= fired || condition_met;
			detect_event <= condition_met && !fired;
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	reg16_t event_set;
	reg16_t event_clear;

	always_comb begin
		event_set                   = 16'h0000;
		event_set[`EVT_DETECT_BIT]  = detect_event;
		event_set[`EVT_SETTLED_BIT] = settle_done;
		event_clear                 = wr_status ? (wr_data & {{8{wr_strb[1]}}, {8{wr_strb[0]}}})
						    : 16'h0000;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			event_status <= 16'h0000;
		end else begin
			// A new event outweighs a clear in the same cycle
			event_status <= (event_set | (event_status & ~event_clear)) & `EVT_MASK;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(event_status & event_mask);
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg16_t live_status;

	assign live_status = {window_count, 1'b0, fired, window_active, measure_enable};

	function automatic reg16_t read_value(input reg_index_t idx);
		case (idx)
			`IDX_CHOP_DETECT_CONFIG: read_value = chop_detect_config;
			`IDX_THRESHOLD_UPPER:    read_value = detect_threshold_upper;
			`IDX_THRESHOLD_LOWER:    read_value = threshold_lower_reg;
			`IDX_EVENT_STATUS:       read_value = event_status;
			`IDX_EVENT_MASK:         read_value = event_mask;
			`IDX_LIVE_STATUS:        read_value = live_status;
			default:                 read_value = 16'h0000;
		endcase
	endfunction : read_value

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
		end else if (!s_axi_rvalid || s_axi_rready) begin
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, read_value(rd_index)};
			s_axi_rresp  <= index_mapped(rd_index) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : chop_and_current_detect_config

`default_nettype wire

// ==== chop_detect_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Port checks of the configuration bank
// ----------------------------------------
module chop_detect_assertions (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        chop_phase_start,
	input wire logic        measure_enable,
	input wire logic        detect_event
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_aw_block;
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("second write address taken");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer changed");
	property p_rdata_hi;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_rdata_hi: assert property (p_rdata_hi) else $error("read data above 16 bits");
	// Only a new chop phase may stop measurement
	property p_settle_cause;
		$fell(measure_enable) |-> $past(chop_phase_start);
	endproperty
	a_settle_cause: assert property (p_settle_cause) else $error("settling without phase");
	property p_evt_pulse;
		detect_event |=> !detect_event;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("detection pulse too long");
	property p_gate;
		!measure_enable [*4] |-> !detect_event;
	endproperty
	a_gate: assert property (p_gate) else $error("detection while settling");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_settle: cover property ($fell(measure_enable));
	c_detect: cover property (detect_event);
endmodule : chop_detect_assertions

`default_nettype wire

// ==== tb_chop_and_current_detect_config.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "chop_detect_regs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_chop_and_current_detect_config;
	import chop_detect_pkg::*;
	localparam logic [23:0] HI = 24'h00_0101;
	localparam logic [23:0] EQ = 24'h00_0100;
	localparam logic [23:0] NEG = 24'hff_feff;
	localparam logic [23:0] LO = 24'h00_0010;
	logic                       clock = 1'b0;
	logic                       nrst = 1'b0;
	logic [7:0]                 s_axi_awaddr = 8'h00;
	logic [7:0]                 s_axi_araddr = 8'h00;
	logic [31:0]                s_axi_wdata = 32'h0000_0000;
	logic [3:0]                 s_axi_wstrb = 4'h0;
	logic                       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic                       mod_tick = 1'b0, chop_phase_start = 1'b0, conv_valid = 1'b0;
	logic [`CHANNELS-1:0][23:0] ch_sample = '0;
	logic                       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                       s_axi_rvalid, measure_enable, detect_event, irq;
	logic [1:0]                 s_axi_bresp, s_axi_rresp, resp;
	logic [31:0]                s_axi_rdata;
	reg16_t                     val;
	int                         miscompares = 0, n_tests = 0, n_det = 0, cyc = 0, k;
	int                         dly[3] = '{0, 3, 15};
	int                         num[3] = '{0, 2, 7};

	chop_and_current_detect_config uut (
		.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.mod_tick, .chop_phase_start, .conv_valid, .ch_sample, .measure_enable, .detect_event, .irq
	);

	always #25 clock = ~clock;
	// Longest chop delay alone takes about 65k cycles
	always @(posedge clock) begin
		if (detect_event === 1'b1) n_det <= n_det + 1;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			miscompares++;
			final_report();
		end
	end

	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic wr(input logic [5:0] idx, input reg16_t d);
		logic a, w, b;
		@(posedge clock);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'h3;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clock);
			a = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clock);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] idx);
		logic a, v;
		@(posedge clock);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clock);
			a = s_axi_arready;
			v = s_axi_rvalid;
			val = s_axi_rdata[15:0];
			resp = s_axi_rresp;
			@(posedge clock);
			if (a) s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rchk(input string nm, input logic [5:0] idx, input reg16_t ex);
		rd(idx);
		`CHK(nm, ex, val)
	endtask : rchk

	function automatic reg16_t config_word(logic [3:0] d, logic ch, al, logic [2:0] n, ln, logic en);
		return {3'h0, d, ch, al, n, ln, en};
	endfunction : config_word

	task automatic arm(input reg16_t v);
		wr(`IDX_CHOP_DETECT_CONFIG, 16'h0000);
		wr(`IDX_CHOP_DETECT_CONFIG, v);
		k = n_det;
	endtask : arm

	task automatic ticks(input int n);
		mod_tick <= 1'b1;
		repeat (n) @(posedge clock);
		mod_tick <= 1'b0;
	endtask : ticks

	task automatic conv(input logic [3:0][23:0] s);
		conv_valid <= 1'b1;
		ch_sample <= s;
		@(posedge clock);
		conv_valid <= 1'b0;
		@(posedge clock);
	endtask : conv

	task automatic dets(input int ex);
		repeat (4) @(posedge clock);
		`CHK("detections", ex, n_det)
	endtask : dets

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		rchk("config", `IDX_CHOP_DETECT_CONFIG, config_word(4'h3, 0, 0, 3'h0, 3'h0, 0));
		rchk("upper", `IDX_THRESHOLD_UPPER, 16'h0000);
		rchk("lower", `IDX_THRESHOLD_LOWER, 16'h0000);
		rchk("mask", `IDX_EVENT_MASK, 16'h0000);
		wr(`IDX_THRESHOLD_UPPER, 16'ha55a);
		rchk("upper", `IDX_THRESHOLD_UPPER, 16'ha55a);
		wr(`IDX_THRESHOLD_UPPER, 16'h0001);
		wr(`IDX_THRESHOLD_LOWER, 16'hffff);
		rchk("lower", `IDX_THRESHOLD_LOWER, 16'hff00);
		wr(`IDX_THRESHOLD_LOWER, 16'h0000);
		wr(`IDX_CHOP_DETECT_CONFIG, 16'h1fff);
		rchk("config", `IDX_CHOP_DETECT_CONFIG, 16'h1fff);
		wr(6'h3f, 16'h1234);
		`CHK("bresp", `AXI_RESP_SLVERR, resp)
		rchk("unmapped", 6'h3f, 16'h0000);
		`CHK("rresp", `AXI_RESP_SLVERR, resp)
		foreach (dly[i]) begin
			wr(`IDX_CHOP_DETECT_CONFIG, config_word(dly[i][3:0], 1, 0, 3'h0, 3'h0, 0));
			chop_phase_start <= 1'b1;
			@(posedge clock);
			chop_phase_start <= 1'b0;
			ticks((2 << dly[i]) - 1);
			@(negedge clock);
			`CHK("settling", 1'b0, measure_enable)
			@(posedge clock);
			ticks(1);
			@(negedge clock);
			`CHK("settled", 1'b1, measure_enable)
			@(posedge clock);
		end
		rchk("status", `IDX_EVENT_STATUS, 16'h0002);
		wr(`IDX_EVENT_STATUS, 16'h0003);
		wr(`IDX_CHOP_DETECT_CONFIG, config_word(4'h5, 0, 0, 3'h0, 3'h0, 0));
		chop_phase_start <= 1'b1;
		@(posedge clock);
		chop_phase_start <= 1'b0;
		@(negedge clock);
		`CHK("chop off", 1'b1, measure_enable)
		@(posedge clock);
		rchk("config", `IDX_CHOP_DETECT_CONFIG, config_word(4'h5, 0, 0, 3'h0, 3'h0, 0));
		wr(`IDX_EVENT_MASK, 16'h0001);
		foreach (num[i]) begin
			arm(config_word(4'h3, 0, 0, num[i][2:0], 3'h1, 1));
			repeat ((1 << num[i]) - 1) conv({LO, LO, LO, HI});
			dets(k);
			conv({LO, LO, LO, HI});
			dets(k + 1);
		end
		@(negedge clock);
		`CHK("irq", 1'b1, irq)
		wr(`IDX_EVENT_MASK, 16'h0000);
		@(negedge clock);
		`CHK("irq masked", 1'b0, irq)
		rchk("status", `IDX_EVENT_STATUS, 16'h0001);
		wr(`IDX_EVENT_MASK, 16'h0001);
		wr(`IDX_EVENT_STATUS, 16'h0001);
		@(negedge clock);
		`CHK("irq cleared", 1'b0, irq)
		arm(config_word(4'h3, 0, 0, 3'h0, 3'h0, 0));
		conv({HI, HI, HI, HI});
		dets(k);
		arm(config_word(4'h3, 0, 1, 3'h0, 3'h0, 1));
		conv({EQ, NEG, HI, HI});
		dets(k);
		conv({HI, NEG, HI, HI});
		dets(k + 1);
		for (int w = 0; w < 2; w++) begin
			arm(config_word(4'h3, 0, 0, 3'h0, w[2:0], 1));
			conv({LO, LO, LO, HI});
			repeat ((w ? 256 : 128) - 2) conv({LO, LO, LO, LO});
			conv({LO, LO, LO, HI});
			dets(k + 1);
			conv({LO, LO, LO, HI});
			dets(k + 2);
		end
		final_report();
	end
endmodule : tb_chop_and_current_detect_config

bind chop_and_current_detect_config chop_detect_assertions chk (
	.clock, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .chop_phase_start, .measure_enable, .detect_event
);

`default_nettype wire
